/* rtl/ahb_host_port.sv */
// host controller driving a 12-bit converter through its parallel port
// assumes device pins are outside this clock domain; inputs are synced
//
// Notes on behaviour
// - byte half select follows address bit zero
// - word write: low byte base, high next
// - twelve-bit bus: one base read suffices
// - other registers: also read base plus one
// - eight-bit bus: always read both locations
// - timer pulses trigger; busy fall raises interrupt
// - chip select plus read strobe access
// - one extra wait via select and done
// - expansion bus fast timing: two waits
// - device placed in top 64 locations
`timescale 1ns/1ps
module ahb_host_port
	import ahb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic [1:0] req_op,
	input wire logic [WORD_W-1:0] req_wdata,
	input wire logic bus8_mode,
	input wire logic [WAIT_W-1:0] wait_count_field,
	input wire logic trig_enable,
	input wire logic [DIV_W-1:0] trig_period,
	output logic req_ready,
	output logic rsp_valid,
	output logic [WORD_W-1:0] rsp_rdata,
	output logic conv_done,
	output logic chip_sel_n,
	output logic rd_n,
	output logic wr_n,
	output logic byte_half_select,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe_n,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic busy_in,
	output logic conversion_trigger_n
);
	typedef enum logic [2:0] {
		AHB_IDLE, AHB_SETUP, AHB_STROBE, AHB_HOLD, AHB_DONE
	} ahb_state_e;
	ahb_state_e st_r, st_nxt; // access phase
	logic [CNT_W-1:0] cnt_r, cnt_nxt; // phase cycle count
	ahb_op_e op_r, op_nxt; // operation in flight
	logic half_r, half_nxt; // second location of a pair
	logic [WORD_W-1:0] wdat_r, wdat_nxt; // word being written
	logic [WORD_W-1:0] rdat_r, rdat_nxt; // assembled read word
	logic cs_r, cs_nxt, rd_r, rd_nxt, wr_r, wr_nxt; // strobes, active low
	logic [DATA_W-1:0] dout_r, dout_nxt; // driven data
	logic oe_r, oe_nxt; // data enable, low drives
	logic rdy_r, rdy_nxt, vld_r, vld_nxt; // request handshake
	logic [DATA_W-1:0] din_s1_r, din_s2_r; // data synchroniser
	logic busy_s1_r, busy_s2_r, busy_s3_r; // busy synchroniser plus edge
	logic done_r, done_nxt; // conversion complete pulse
	logic [CNT_W-1:0] strobe_len; // strobe low time including waits
	logic [ADDR_W-1:0] addr_r, addr_nxt; // host address of the access
	logic [ADDR_W-1:0] device_base_location; // decoder base, top window

	// base sits in the highest 64 locations of the peripheral space
	assign device_base_location = BASE_LOC;

	// strobe grows by the configured waits; one wait covers the
	// select-with-done case, two cover fast expansion-bus hosts
	assign strobe_len = ahb_cyc(STROBE_CYC)
		+ CNT_W'(wait_count_field);

	// pins from the device pass two flops before use
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			din_s1_r <= '0;
			din_s2_r <= '0;
			busy_s1_r <= 1'b0;
			busy_s2_r <= 1'b0;
			busy_s3_r <= 1'b0;
		end else begin
			din_s1_r <= data_in;
			din_s2_r <= din_s1_r;
			busy_s1_r <= busy_in;
			busy_s2_r <= busy_s1_r;
			busy_s3_r <= busy_s2_r;
		end
	end

	// busy falling edge stands in for the host interrupt
	always_comb begin
		done_nxt = busy_s3_r && !busy_s2_r;
	end

	// access sequencer next state
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		op_nxt = op_r;
		half_nxt = half_r;
		addr_nxt = addr_r;
		wdat_nxt = wdat_r;
		rdat_nxt = rdat_r;
		cs_nxt = cs_r;
		rd_nxt = rd_r;
		wr_nxt = wr_r;
		dout_nxt = dout_r;
		oe_nxt = oe_r;
		rdy_nxt = rdy_r;
		vld_nxt = 1'b0;
		unique case (st_r)
			AHB_IDLE: begin
				if (req_valid && rdy_r) begin
					op_nxt = ahb_op_e'(req_op);
					wdat_nxt = req_wdata;
					rdat_nxt = '0;
					half_nxt = 1'b0; // base location first
					addr_nxt = device_base_location;
					rdy_nxt = 1'b0; // no other access until pair ends
					cnt_nxt = ahb_cyc(SETUP_CYC);
					cs_nxt = 1'b0;
					st_nxt = AHB_SETUP;
					if (ahb_op_e'(req_op) == AHB_OP_WR_WORD) begin
						dout_nxt = {{(DATA_W-BYTE_W){1'b0}},
							req_wdata[BYTE_W-1:0]};
						oe_nxt = 1'b0;
					end
				end
			end
			AHB_SETUP: begin
				if (cnt_r <= 1) begin
					cnt_nxt = strobe_len;
					if (op_r == AHB_OP_WR_WORD) begin
						wr_nxt = 1'b0;
					end else begin
						rd_nxt = 1'b0;
					end
					st_nxt = AHB_STROBE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			AHB_STROBE: begin
				if (cnt_r <= 1) begin
					// sample at the read rise, allowing two sync stages
					if (!rd_r) begin
						if (!half_r) begin
							rdat_nxt[DATA_W-1:0] = din_s2_r;
							if (bus8_mode) begin
								// lines 8 to 11 are not wired on a byte bus
								rdat_nxt[DATA_W-1:BYTE_W] = '0;
							end
						end else begin
							rdat_nxt[WORD_W-1:BYTE_W] = din_s2_r[BYTE_W-1:0];
						end
					end
					rd_nxt = 1'b1;
					wr_nxt = 1'b1; // device latches here
					cnt_nxt = ahb_cyc(HOLD_CYC);
					st_nxt = AHB_HOLD;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			AHB_HOLD: begin
				if (cnt_r <= 1) begin
					cs_nxt = 1'b1;
					oe_nxt = 1'b1;
					st_nxt = AHB_DONE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			AHB_DONE: begin
				// second location when the pair needs it
				if (!half_r && (op_r != AHB_OP_RD_LO || bus8_mode)) begin
					half_nxt = 1'b1; // base plus one
					addr_nxt = {device_base_location[ADDR_W-1:1], 1'b1};
					cs_nxt = 1'b0;
					cnt_nxt = ahb_cyc(SETUP_CYC);
					if (op_r == AHB_OP_WR_WORD) begin
						dout_nxt = {{(DATA_W-BYTE_W){1'b0}},
							wdat_r[WORD_W-1:BYTE_W]};
						oe_nxt = 1'b0;
					end
					st_nxt = AHB_SETUP;
				end else begin
					// a pair's high byte read has filled bits 15 to 8; a lone twelve-bit read leaves 15 to 12 clear
					vld_nxt = (op_r != AHB_OP_WR_WORD);
					rdy_nxt = 1'b1;
					st_nxt = AHB_IDLE;
				end
			end
			default: st_nxt = AHB_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= AHB_IDLE;
			cnt_r <= '0;
			op_r <= AHB_OP_RD_LO;
			half_r <= 1'b0;
			addr_r <= '0;
			wdat_r <= '0;
			rdat_r <= '0;
			cs_r <= 1'b1;
			rd_r <= 1'b1;
			wr_r <= 1'b1;
			dout_r <= '0;
			oe_r <= 1'b1;
			rdy_r <= 1'b1;
			vld_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			op_r <= op_nxt;
			half_r <= half_nxt;
			addr_r <= addr_nxt;
			wdat_r <= wdat_nxt;
			rdat_r <= rdat_nxt;
			cs_r <= cs_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
			dout_r <= dout_nxt;
			oe_r <= oe_nxt;
			rdy_r <= rdy_nxt;
			vld_r <= vld_nxt;
			done_r <= done_nxt;
		end
	end

	// external sample-rate timer for the trigger pin
	ahb_trig_timer u_timer (
		.clk(clk),
		.rst_n(rst_n),
		.enable(trig_enable),
		.period(trig_period),
		.conversion_trigger_n(conversion_trigger_n)
	);

	assign req_ready = rdy_r;
	assign rsp_valid = vld_r;
	assign rsp_rdata = rdat_r;
	assign conv_done = done_r;
	assign chip_sel_n = cs_r;
	assign rd_n = rd_r;
	assign wr_n = wr_r;
	assign byte_half_select = addr_r[0]; // address bit zero
	assign data_out = dout_r;
	assign data_oe_n = oe_r;

	a_half_strobe: assert property (@(posedge clk) disable iff (!rst_n)
		(!rd_r || !wr_r) |-> !cs_r)
		else $error("strobe without chip select");
	a_write_pair: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(wr_r) && !half_r && op_r == AHB_OP_WR_WORD
		|-> ##[1:40] (!wr_r && half_r))
		else $error("high byte write missing");
	a_pair_locked: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r != AHB_IDLE) |-> !rdy_r)
		else $error("ready during pair");
	a_oe_write: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(wr_r) |-> !oe_r && dout_r[DATA_W-1:BYTE_W] == '0)
		else $error("write data not driven");
	a_no_drive_rd: assert property (@(posedge clk) disable iff (!rst_n)
		!rd_r |-> oe_r)
		else $error("contention on read");
	a_strobe_len: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(rd_r) |-> (!rd_r)[*8])
		else $error("read strobe too short");
	a_bus8_two: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(rd_r) && bus8_mode && !half_r |-> ##[1:40] (!rd_r && half_r))
		else $error("second read missing");
	a_top_window: assert property (@(posedge clk) disable iff (!rst_n)
		!cs_r |-> addr_r[ADDR_W-1:TOP_WIN_W] == '1 && addr_r[0] == half_r)
		else $error("access outside top window");
	a_done_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		done_r |-> ##1 !done_r)
		else $error("done not a pulse");
endmodule : ahb_host_port

/* rtl/ahb_pkg.sv */
// package for the host-side attachment of a 12-bit converter parallel port
// assumes one 200 MHz clock; all constants but WAIT_DEF and DIV_DEF are used by rtl files
package ahb_pkg;
	localparam int CLK_MHZ = 200; // system clock rate
	localparam int DATA_W = 12; // device data lines
	localparam int BYTE_W = 8; // low data lines used for writes and hi reads
	localparam int WORD_W = 16; // register word width
	localparam logic [3:0] WAIT_DEF = 4'h2; // default inserted wait states
	localparam int WAIT_W = 4; // width of wait_count_field
	localparam int SETUP_NS = 10; // address and data setup before strobe
	localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_NS = 50; // least strobe low time
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOLD_NS = 10; // hold after strobe rise
	localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
	localparam int TRIG_NS = 20; // conversion trigger low pulse
	localparam int TRIG_CYC = (TRIG_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 8; // phase counter width
	localparam int DIV_W = 16; // sample timer width
	localparam logic [DIV_W-1:0] DIV_DEF = 16'h03e8; // default sample period
	localparam int ADDR_W = 16; // host address width seen by the decoder
	localparam int TOP_WIN_W = 6; // 64-location peripheral window
	// even base so address bit zero alone picks the byte half
	localparam logic [ADDR_W-1:0] BASE_LOC = 16'hffc0;
	// host operations
	typedef enum logic [1:0] {
		AHB_OP_RD_LO,  // one read at base location, two on a byte bus
		AHB_OP_RD_BOTH, // read base then base plus one
		AHB_OP_WR_WORD  // write low byte then high byte
	} ahb_op_e;
	// width-truncating conversion of a cycle count, floored at one
	function automatic logic [CNT_W-1:0] ahb_cyc(input int n);
		ahb_cyc = CNT_W'(n < 1 ? 1 : n);
	endfunction : ahb_cyc
endpackage : ahb_pkg

/* rtl/ahb_trig_timer.sv */
// sample-rate timer producing the active-low conversion trigger pulse
// assumes the period input is stable while enabled
`timescale 1ns/1ps
module ahb_trig_timer
	import ahb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [DIV_W-1:0] period,
	output logic conversion_trigger_n
);
	logic [DIV_W-1:0] cnt_r, cnt_nxt; // cycles until next trigger
	logic [CNT_W-1:0] low_r, low_nxt; // remaining low time of the pulse
	logic trig_r, trig_nxt; // registered pin level
	// next state: count down, fire a fixed-width low pulse at zero
	always_comb begin
		cnt_nxt = cnt_r;
		low_nxt = low_r;
		trig_nxt = 1'b1;
		if (low_r != '0) begin
			low_nxt = low_r - 1'b1;
			trig_nxt = 1'b0;
		end
		if (!enable) begin
			cnt_nxt = period; // restart cleanly when re-enabled
		end else if (cnt_r == '0) begin
			cnt_nxt = period;
			// the pin goes low on this edge, so one cycle is already spent
			low_nxt = ahb_cyc(TRIG_CYC) - 1'b1;
			trig_nxt = 1'b0;
		end else begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end
	// registers only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			low_r <= '0;
			trig_r <= 1'b1;
		end else begin
			cnt_r <= cnt_nxt;
			low_r <= low_nxt;
			trig_r <= trig_nxt;
		end
	end
	assign conversion_trigger_n = trig_r;
	// trigger pulse keeps its low width
	a_trig_width: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(trig_r) |-> (!trig_r)[*4])
		else $error("trigger pulse too short");
endmodule : ahb_trig_timer

/* tb/ahb_dev_model.sv */
// behavioural model of the converter's parallel port and busy timing
// assumes the controller drives cs, strobes and byte half select registered
`timescale 1ns/1ps
module ahb_dev_model
	import ahb_pkg::*;
#(
	parameter int BUSY_CYC = 30, // conversion length in clocks
	parameter logic [15:0] INIT_WORD = 16'h0000 // register word after power-up
) (
	input wire logic clk,
	input wire logic chip_sel_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic byte_half_select,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic conversion_trigger_n,
	output logic [DATA_W-1:0] data_in,
	output logic busy_in,
	output int busy_falls
);
	logic [15:0] word_r = INIT_WORD; // the one register word held
	logic [DATA_W-1:0] last_r = '0; // last value seen on the data lines
	logic trig_q = 1'b1; // trigger delayed for edge detection
	int busy_cnt = 0; // clocks left in the conversion
	wire rd_en = !chip_sel_n && !rd_n; // level-sensitive gated enable
	// released lines show the inverse of the last value, never a stale copy
	// upper four lines on a high-half read are not driven, so they toggle
	assign data_in = !rd_en ? ~last_r : byte_half_select ?
		{~last_r[11:8], word_r[15:8]} : word_r[11:0];
	// write data latched from the low byte lines on the strobe's rise
	always @(posedge wr_n) begin
		if (!chip_sel_n && byte_half_select) word_r[15:8] <= data_out[7:0];
		else if (!chip_sel_n) word_r[7:0] <= data_out[7:0];
	end
	// busy rises on the trigger's falling edge and falls after the conversion
	always @(posedge clk) begin
		last_r <= data_in;
		trig_q <= conversion_trigger_n;
		if (trig_q && !conversion_trigger_n && busy_cnt == 0) begin
			busy_cnt <= BUSY_CYC;
		end else if (busy_cnt == 1) begin
			busy_cnt <= 0;
			busy_falls <= busy_falls + 1; // this fall is the interrupt
		end else if (busy_cnt > 0) begin
			busy_cnt <= busy_cnt - 1;
		end
	end
	assign busy_in = busy_cnt > 0;
	initial busy_falls = 0;
endmodule : ahb_dev_model

/* tb/ahb_host_port_tb.sv */
// self-checking bench for the host port against the converter model
// assumes a 200 MHz clock; inputs change on the falling edge
`timescale 1ns/1ps
module ahb_host_port_tb
	import ahb_pkg::*;
;
	logic clk, rst_n, req_valid, bus8_mode, trig_enable; // stimulus
	logic [1:0] req_op; // operation code
	logic [WORD_W-1:0] req_wdata; // word to write
	logic [WAIT_W-1:0] wait_count_field; // extra strobe cycles
	logic [DIV_W-1:0] trig_period; // trigger spacing
	logic req_ready, rsp_valid, conv_done, chip_sel_n, rd_n, wr_n; // outputs
	logic byte_half_select, data_oe_n, busy_in, conversion_trigger_n;
	logic [WORD_W-1:0] rsp_rdata; // read result
	logic [DATA_W-1:0] data_out, data_in; // device data lines
	int num_errors = 0, comparisons = 0, busy_falls, done_cnt = 0, low_run = 0;
	integer seed = 32'h1e40338c; // fixed seed
	logic [31:0] exp_q[$]; // expected {mask, word} notes, oldest first
	logic [15:0] word; // what the device should hold
	ahb_host_port i_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_op(req_op), .req_wdata(req_wdata), .bus8_mode(bus8_mode),
		.wait_count_field(wait_count_field), .trig_enable(trig_enable),
		.trig_period(trig_period), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .conv_done(conv_done),
		.chip_sel_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n),
		.byte_half_select(byte_half_select), .data_out(data_out),
		.data_oe_n(data_oe_n), .data_in(data_in), .busy_in(busy_in),
		.conversion_trigger_n(conversion_trigger_n));
	ahb_dev_model i_dev (.clk(clk), .chip_sel_n(chip_sel_n), .rd_n(rd_n),
		.wr_n(wr_n), .byte_half_select(byte_half_select),
		.data_out(data_out), .conversion_trigger_n(conversion_trigger_n),
		.data_in(data_in), .busy_in(busy_in), .busy_falls(busy_falls));
	// free-running clock, 5 ns period
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// one comparison of a read word under a mask
	task automatic check_word(input logic [15:0] got, input logic [31:0] e);
		comparisons++;
		if ((got & e[31:16]) !== e[15:0]) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, e[15:0]);
		end
	endtask : check_word
	// one comparison of a count
	task automatic check_count(input int got, input int exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_count
	// issue one request with random waits, then wait for the port to be free
	task automatic do_op(input logic [1:0] op, input logic [15:0] wd);
		int n;
		wait_count_field = 4'($random(seed) & 3);
		req_op = op;
		req_wdata = wd;
		req_valid = 1'b1;
		@(posedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		repeat (2) @(negedge clk);
		for (n = 0; n < 300 && req_ready !== 1'b1; n++) @(negedge clk);
		if (n == 300) check_count(n, 0);
	endtask : do_op
	// closing verdict
	task automatic report_and_stop();
		$display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	// watcher at the falling edge, where registered outputs have settled
	always @(negedge clk) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) check_count(1, 0);
			else check_word(rsp_rdata, exp_q.pop_front());
		end
		if (conv_done === 1'b1) done_cnt++;
		if (conversion_trigger_n === 1'b0) low_run++;
		else if (low_run != 0) begin
			check_count(low_run, TRIG_CYC);
			low_run = 0;
		end
	end
	// watchdog well beyond the expected run length
	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end
	// main sequence
	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_op = 2'h0;
		req_wdata = 16'h0000;
		bus8_mode = 1'b0;
		wait_count_field = 4'h0;
		trig_enable = 1'b0;
		trig_period = 16'h0080;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		trig_enable = 1'b1; // conversions run under the traffic
		for (int i = 0; i < 8; i++) begin
			word = 16'($random(seed));
			bus8_mode = i[0];
			do_op(2'h2, word);
			// both locations give the whole word on either bus width
			exp_q.push_back({16'hffff, word});
			do_op(2'h1, 16'h0000);
			// one base read: twelve bits, or two reads on a byte bus
			if (bus8_mode) exp_q.push_back({16'hffff, word});
			else exp_q.push_back({16'hffff, 4'h0, word[11:0]});
			do_op(2'h0, 16'h0000);
		end
		@(negedge clk);
		trig_enable = 1'b0;
		repeat (60) @(negedge clk);
		check_count(exp_q.size(), 0);
		check_count(done_cnt, busy_falls);
		report_and_stop();
	end
endmodule : ahb_host_port_tb
